// file: logic/pcal_params.svh
`ifndef PCAL_PARAMS_SVH
`define PCAL_PARAMS_SVH

`define PCAL_ADDR_CALIB_STATUS      8'h00_DC
`define PCAL_ADDR_IRQ_ENABLES       8'h00_DD
`define PCAL_STATUS_DONE_BIT        0
`define PCAL_EN_AMB_SAT_BIT         7
`define PCAL_EN_PROX_SAT_BIT        6
`define PCAL_EN_PROX_THR_BIT        5
`define PCAL_EN_AMB_COL_BIT         4
`define PCAL_EN_CALIB_BIT           3
`define PCAL_EN_WRITABLE_MASK       8'h00_F8
`define PCAL_IRQ_ENABLES_RESET      8'h00_00
`define PCAL_CALIB_STATUS_RESET     8'h00_00
`define PCAL_TARGET_RESET           3'h2
`define PCAL_AVG_RESET              3'h0

`endif

// file: logic/pcal_pkg.sv
`default_nettype none
package pcal_pkg;
	typedef enum logic [1:0] {
		PCAL_IDLE   = 2'b00,
		PCAL_SEARCH = 2'b01,
		PCAL_FINISH = 2'b10
	} pcal_state_t;

	typedef struct packed {
		pcal_state_t state;
		logic [7:0]  offset_magnitude;
		logic        offset_sign_holder;
		logic [7:0]  step;
		logic        settle;
		logic        calibration_done_flag;
		logic [7:0]  irq_enables;
		logic [7:0]  rdata;
		logic        irq_out;
		logic        done_pulse;
	} pcal_regs_t;

	typedef struct packed {
		logic [7:0]  count;
		logic [14:0] sum;
		logic [7:0]  result;
		logic        valid;
	} pcal_avg_regs_t;
endpackage
`default_nettype wire

// file: logic/pcal_averager.sv
`include "pcal_params.svh"
`default_nettype none
module pcal_averager #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [2:0]   proximity_average_count,
	input  wire logic         sample_valid,
	input  wire logic [W-1:0] sample,
	output logic              result_valid,
	output logic [W-1:0]      proximity_result
);
	pcal_pkg::pcal_avg_regs_t s_reg;
	pcal_pkg::pcal_avg_regs_t s_next;
	logic [14:0] acc;

	// 2^n samples summed, then shifted by n; n = 0 passes each sample
	always_comb
	begin
		s_next = s_reg;
		s_next.valid = 1'b0;
		acc = s_reg.sum + 15'(sample);
		if (sample_valid)
		begin
			if (s_reg.count == 8'((9'd1 << proximity_average_count) - 9'd1))
			begin
				s_next.result = 8'(acc >> proximity_average_count);
				s_next.valid = 1'b1;
				s_next.sum = '0;
				s_next.count = '0;
			end
			else
			begin
				s_next.sum = acc;
				s_next.count = s_reg.count + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign result_valid = s_reg.valid;
	assign proximity_result = s_reg.result;
endmodule // pcal_averager
`default_nettype wire

// file: logic/pcal_core.sv
`include "pcal_params.svh"
`default_nettype none
// Summary of operation
// - calibration drives no-object result toward target
// - nonzero target keeps baseline above zero
// - result is average of converter samples
// - done flag bit 0 sets; resets 0
// - done flag clears only on write one
// - enable bits 7,4,3 gate ALS, colour, calibration
// - bit 6 prox saturation; threshold enable; reserved low
// - target equals two-power code minus one; code 0 gives 1
// - averaging 0 off, n gives 2^n samples
// - result loads offset registers automatically
module pcal_core (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic [2:0] baseline_target_code,
	input  wire logic [2:0] proximity_average_count,
	input  wire logic       calibration_start_bit,
	input  wire logic       sample_valid,
	input  wire logic [7:0] sample,
	input  wire logic       ambient_sat_flag,
	input  wire logic       proximity_sat_flag,
	input  wire logic       proximity_thr_flag,
	input  wire logic       ambient_colour_flag,
	output logic [7:0]      reg_rdata,
	output logic [7:0]      proximity_result,
	output logic            proximity_result_valid,
	output logic [7:0]      offset_magnitude,
	output logic            offset_sign_holder,
	output logic            calibration_done_pulse,
	output logic            irq_out
);
	pcal_pkg::pcal_regs_t r_reg;
	pcal_pkg::pcal_regs_t r_next;
	logic       avg_valid;
	logic [7:0] avg_result;
	logic [7:0] target;
	logic       wr_status;
	logic       wr_enables;
	logic       pending;

	pcal_averager #(
		.W(8)
	) u_avg (
		.clk                     (clk),
		.reset                   (reset),
		.proximity_average_count (proximity_average_count),
		.sample_valid            (sample_valid),
		.sample                  (sample),
		.result_valid            (avg_valid),
		.proximity_result        (avg_result)
	);

	////////////////////////////////////////////////////////////////////////
	// code 0 would give a zero target; forced to 1 so baseline stays above 0
	assign target = (baseline_target_code == 3'h0) ? 8'h01
		: 8'((9'd1 << baseline_target_code) - 9'd1);

	assign wr_status = reg_write && (reg_addr == `PCAL_ADDR_CALIB_STATUS);
	assign wr_enables = reg_write && (reg_addr == `PCAL_ADDR_IRQ_ENABLES);

	always_comb
	begin
		r_next = r_reg;
		r_next.done_pulse = 1'b0;
		pending = 1'b0;
		////////////////////////////////////////////////////////////////////
		// signed offset search: each averaged result moves the offset by a
		// halving step; a positive offset raises the result
		case (r_reg.state)
			pcal_pkg::PCAL_IDLE:
			begin
				if (calibration_start_bit)
				begin
					r_next.state = pcal_pkg::PCAL_SEARCH;
					r_next.offset_magnitude = 8'h00;
					r_next.offset_sign_holder = 1'b0;
					r_next.step = 8'h80;
				end
			end
			pcal_pkg::PCAL_SEARCH:
			begin
				if (avg_valid)
				begin
					if (avg_result == target || r_reg.step == 8'h00)
						r_next.state = pcal_pkg::PCAL_FINISH;
					else if ((avg_result > target) == r_reg.offset_sign_holder)
					begin
						r_next.offset_magnitude = r_reg.offset_magnitude + r_reg.step;
					end
					else if (r_reg.offset_magnitude >= r_reg.step)
						r_next.offset_magnitude = r_reg.offset_magnitude - r_reg.step;
					else
					begin
						r_next.offset_magnitude = r_reg.step - r_reg.offset_magnitude;
						r_next.offset_sign_holder = ~r_reg.offset_sign_holder;
					end
					r_next.step = {1'b0, r_reg.step[7:1]};
					// a zero result at step zero is not a fit: stay in search, offset magnitude plus one
					if (avg_result == 8'h00 && r_reg.step == 8'h00)
						r_next.state = pcal_pkg::PCAL_SEARCH;
				end
			end
			pcal_pkg::PCAL_FINISH:
			begin
				// offset already sits in the offset registers; no host load needed
				r_next.done_pulse = 1'b1;
				r_next.state = pcal_pkg::PCAL_IDLE;
			end
			default:
				r_next.state = pcal_pkg::PCAL_IDLE;
		endcase
		if (r_reg.state == pcal_pkg::PCAL_SEARCH && avg_valid && avg_result == 8'h00
			&& r_reg.step == 8'h00)
		begin
			r_next.offset_magnitude = r_reg.offset_magnitude + 8'h01;
		end

		////////////////////////////////////////////////////////////////////
		// set wins over a same-cycle write-one clear
		if (wr_status && reg_wdata[`PCAL_STATUS_DONE_BIT])
			r_next.calibration_done_flag = 1'b0;
		if (r_reg.state == pcal_pkg::PCAL_FINISH)
			r_next.calibration_done_flag = 1'b1;

		// reserved bits 2:0 stay zero
		if (wr_enables)
			r_next.irq_enables = reg_wdata & `PCAL_EN_WRITABLE_MASK;

		pending =
			(r_reg.irq_enables[`PCAL_EN_AMB_SAT_BIT] && ambient_sat_flag)
			|| (r_reg.irq_enables[`PCAL_EN_PROX_SAT_BIT] && proximity_sat_flag)
			|| (r_reg.irq_enables[`PCAL_EN_PROX_THR_BIT] && proximity_thr_flag)
			|| (r_reg.irq_enables[`PCAL_EN_AMB_COL_BIT] && ambient_colour_flag)
			|| (r_reg.irq_enables[`PCAL_EN_CALIB_BIT] && r_reg.calibration_done_flag);
		r_next.irq_out = pending;

		r_next.rdata = 8'h00;
		if (reg_read && reg_addr == `PCAL_ADDR_CALIB_STATUS)
			r_next.rdata = {7'h00, r_reg.calibration_done_flag};
		else if (reg_read && reg_addr == `PCAL_ADDR_IRQ_ENABLES)
			r_next.rdata = r_reg.irq_enables;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			r_reg <= '0;
			r_reg.state <= pcal_pkg::PCAL_IDLE;
		end
		else
			r_reg <= r_next;
	end

	logic [7:0] res_reg;
	logic       res_valid_reg;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			res_reg <= 8'h00;
			res_valid_reg <= 1'b0;
		end
		else
		begin
			res_valid_reg <= avg_valid;
			if (avg_valid)
				res_reg <= avg_result;
		end
	end

	assign reg_rdata = r_reg.rdata;
	assign proximity_result = res_reg;
	assign proximity_result_valid = res_valid_reg;
	assign offset_magnitude = r_reg.offset_magnitude;
	assign offset_sign_holder = r_reg.offset_sign_holder;
	assign calibration_done_pulse = r_reg.done_pulse;
	assign irq_out = r_reg.irq_out;
endmodule // pcal_core
`default_nettype wire

// file: verification/pcal_core_asserts.sv
`include "pcal_params.svh"
`default_nettype none
module pcal_core_asserts (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [2:0] proximity_average_count,
	input wire logic       sample_valid,
	input wire logic       ambient_sat_flag,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] proximity_result,
	input wire logic       proximity_result_valid,
	input wire logic       calibration_done_pulse,
	input wire logic       irq_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	wire en_wr = reg_write && reg_addr == `PCAL_ADDR_IRQ_ENABLES;
	wire en_rd = reg_read && reg_addr == `PCAL_ADDR_IRQ_ENABLES;
	wire st_rd = reg_read && reg_addr == `PCAL_ADDR_CALIB_STATUS;
	////////////////////////////////////////
	chk_rsvd_zero: assert property ($past(en_rd) |-> reg_rdata[2:0] == 3'h0)
		else $error("reserved enable bits read nonzero");
	chk_en_readback: assert property (en_wr ##1 !reg_write ##1 (en_rd && !reg_write) |=>
		reg_rdata == ($past(reg_wdata, 3) & `PCAL_EN_WRITABLE_MASK))
		else $error("enable readback wrong");
	chk_irq_off: assert property ((en_wr && reg_wdata == 8'h00) ##1 !reg_write |=> !irq_out)
		else $error("interrupt with all enables clear");
	chk_irq_amb: assert property ((en_wr && reg_wdata[`PCAL_EN_AMB_SAT_BIT]) ##1
		(ambient_sat_flag && !reg_write) |=> irq_out)
		else $error("ambient saturation interrupt missing");
	chk_done_single: assert property (calibration_done_pulse |=> !calibration_done_pulse)
		else $error("done pulse longer than one cycle");
	chk_flag_set: assert property (calibration_done_pulse ##1 (st_rd && !reg_write) |=> reg_rdata[0])
		else $error("done flag not set after calibration");
	chk_result_hold: assert property (!proximity_result_valid |-> $stable(proximity_result))
		else $error("result changed without valid");
	chk_avg_bypass: assert property ((sample_valid && proximity_average_count == 3'h0)
		|=> ##[0:1] proximity_result_valid)
		else $error("unaveraged sample gave no result");
endmodule // pcal_core_asserts
bind pcal_core pcal_core_asserts u_pcal_core_asserts (.*);
`default_nettype wire

// file: verification/pcal_sensor_model.sv
`default_nettype none
module pcal_sensor_model (
	input wire logic       clk,
	input wire logic       run,
	input wire logic [7:0] level,
	input wire logic [7:0] offset_magnitude,
	input wire logic       offset_sign_holder,
	output logic           sample_valid,
	output logic [7:0]     sample
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph = 2'h0;
	int         v;
	initial sample_valid = 1'b0;
	initial sample = 8'h00;
	// sign clear raises the result, sign set lowers it, as the search assumes
	always @(posedge clk)
	begin
		ph <= ph + 2'h1;
		v = offset_sign_holder ? level - offset_magnitude : level + offset_magnitude;
		sample_valid <= run && ph == 2'h0;
		// line is not held between samples, so it toggles
		sample <= (run && ph == 2'h0) ? 8'(v < 0 ? 0 : (v > 255 ? 255 : v)) : ~sample;
	end
endmodule // pcal_sensor_model
`default_nettype wire

// file: verification/pcal_core_tb_top.sv
`include "pcal_params.svh"
`default_nettype none
module pcal_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, reset = 1, reg_write = 0, reg_read = 0, rd_d = 0;
	logic        run = 0, calibration_start_bit = 0, ambient_sat_flag = 0;
	logic [7:0]  reg_addr = '0, reg_wdata = '0, level = 8'h64, cnt = '0;
	logic [2:0]  proximity_average_count = '0, src_flags = '0;
	logic [14:0] acc = '0;
	logic [7:0]  reg_rdata, proximity_result, offset_magnitude, sample;
	logic        sample_valid, proximity_result_valid, offset_sign_holder;
	logic        calibration_done_pulse, irq_out;
	logic [7:0]  rd_q[$], res_q[$];
	int          mismatches = 0, compares = 0, i;
	pcal_core u_pcal_core (.clk, .reset, .reg_write, .reg_read, .reg_addr, .reg_wdata,
		.baseline_target_code(3'h4), .proximity_average_count, .calibration_start_bit,
		.sample_valid, .sample, .ambient_sat_flag, .proximity_sat_flag(src_flags[2]),
		.proximity_thr_flag(src_flags[1]), .ambient_colour_flag(src_flags[0]),
		.reg_rdata, .proximity_result,
		.proximity_result_valid, .offset_magnitude, .offset_sign_holder,
		.calibration_done_pulse, .irq_out);
	pcal_sensor_model u_pcal_sensor_model (.clk, .run, .level, .offset_magnitude,
		.offset_sign_holder, .sample_valid, .sample);
	initial forever #2.5 clk = ~clk;
	////////////////////////////////////////
	task automatic print_verdict;
		if (mismatches == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp);
		cmp8({7'h0, got}, {7'h0, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_write <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 0;
		// idle edge so the next strobe is never re-raised in the same step
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_read <= 1;
		reg_addr <= a;
		rd_q.push_back(e);
		@(posedge clk);
		reg_read <= 0;
		@(posedge clk);
	endtask
	task automatic chk_irq(input logic e);
		repeat (2) @(posedge clk);
		@(negedge clk);
		cmp1(irq_out, e);
		@(posedge clk);
	endtask
	////////////////////////////////////////
	always @(posedge clk) rd_d <= reg_read;
	// expected results are built from the samples the sensor really sent
	always @(posedge clk)
	begin
		if (reset)
		begin
			acc <= '0;
			cnt <= '0;
		end
		else if (sample_valid === 1'b1)
		begin
			if (cnt + 1 == (1 << proximity_average_count))
			begin
				res_q.push_back(8'((acc + 15'(sample)) >> proximity_average_count));
				acc <= '0;
				cnt <= '0;
			end
			else
			begin
				acc <= acc + 15'(sample);
				cnt <= cnt + 8'h1;
			end
		end
	end
	always @(negedge clk)
	begin
		if (rd_d && rd_q.size() > 0) cmp8(reg_rdata, rd_q.pop_front());
		if (proximity_result_valid === 1'b1 && res_q.size() > 0)
			cmp8(proximity_result, res_q.pop_front());
	end
	initial
	begin
		void'($urandom(98014));
		repeat (10) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		rd(`PCAL_ADDR_CALIB_STATUS, `PCAL_CALIB_STATUS_RESET);
		rd(`PCAL_ADDR_IRQ_ENABLES, `PCAL_IRQ_ENABLES_RESET);
		for (i = 0; i < 8; i++)
		begin
			wr(`PCAL_ADDR_IRQ_ENABLES, 8'h01 << i);
			rd(`PCAL_ADDR_IRQ_ENABLES, (8'h01 << i) & `PCAL_EN_WRITABLE_MASK);
		end
		wr(8'hDE, 8'hFF);
		rd(8'hDE, 8'h00);
		ambient_sat_flag <= 1;
		wr(`PCAL_ADDR_IRQ_ENABLES, 8'h80);
		chk_irq(1);
		for (i = 0; i < 3; i++)
		begin
			src_flags <= 3'h4 >> i;
			wr(`PCAL_ADDR_IRQ_ENABLES, 8'h40 >> i);
			chk_irq(1);
		end
		wr(`PCAL_ADDR_IRQ_ENABLES, 8'h00);
		chk_irq(0);
		ambient_sat_flag <= 0;
		src_flags <= '0;
		run <= 1;
		wr(`PCAL_ADDR_IRQ_ENABLES, 8'h08);
		calibration_start_bit <= 1;
		@(posedge clk);
		calibration_start_bit <= 0;
		for (i = 0; i < 2000 && calibration_done_pulse !== 1'b1; i++) @(negedge clk);
		if (i == 2000)
		begin
			mismatches++;
			print_verdict();
		end
		@(posedge clk);
		rd(`PCAL_ADDR_CALIB_STATUS, 8'h01);
		chk_irq(1);
		wr(`PCAL_ADDR_CALIB_STATUS, 8'h00);
		rd(`PCAL_ADDR_CALIB_STATUS, 8'h01);
		wr(`PCAL_ADDR_CALIB_STATUS, 8'h01);
		rd(`PCAL_ADDR_CALIB_STATUS, 8'h00);
		chk_irq(0);
		@(negedge clk);
		cmp1(proximity_result != 8'h00, 1'b1);
		@(posedge clk);
		run <= 0;
		repeat (8) @(posedge clk);
		reset <= 1;
		proximity_average_count <= 3'h2;
		repeat (2) @(posedge clk);
		reset <= 0;
		run <= 1;
		for (i = 0; i < 40; i++)
		begin
			level <= 8'($urandom);
			repeat (4) @(posedge clk);
		end
		run <= 0;
		repeat (10) @(posedge clk);
		print_verdict();
	end
endmodule // pcal_core_tb_top
`default_nettype wire
